// file: hw/tmr_regs.v
// Register bank of the thermal monitor, reached through an 8-bit addressed port.
// Assumes the SMBus engine presents one-cycle read and write strobes on clk,
// and the measurement engine delivers results with a one-cycle update strobe.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"

module tmr_regs (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Host register port
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data,
    // Measurement engine results
    input  wire       meas_valid,
    input  wire [7:0] meas_int_temp,
    input  wire [7:0] meas_r1_temp,
    input  wire [7:0] meas_r1_frac,
    input  wire [7:0] meas_r2_temp,
    input  wire [7:0] meas_r2_frac,
    input  wire [1:0] meas_fault,
    input  wire       meas_busy,
    // Controls to the measurement engine
    output wire [7:0] config_out,
    output wire [7:0] rate_out,
    output reg        one_shot,
    // Alert and critical outputs
    output reg        alert,
    output wire       crit
);

    // ****************************************
    // Local constants
    // ****************************************
    localparam [7:0] RST_QUEUE_BYTE = `TMR_RST_QUEUE;

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0] int_temp;
    reg [7:0] r1_temp;
    reg [7:0] r1_frac;
    reg [7:0] r2_temp;
    reg [7:0] r2_frac;
    reg [7:0] err_flags;
    reg [7:0] device_config;
    reg [7:0] sample_rate;
    reg [7:0] int_hi;
    reg [7:0] int_lo;
    reg [7:0] r1_hi_int;
    reg [7:0] r1_lo_int;
    reg [7:0] r1_hi_frac;
    reg [7:0] r1_lo_frac;
    reg [7:0] r2_hi_int;
    reg [7:0] r2_lo_int;
    reg [7:0] r2_hi_frac;
    reg [7:0] r2_lo_frac;
    reg [7:0] int_crit;
    reg [7:0] r1_crit;
    reg [7:0] r2_crit;
    reg [1:0] fault_flags;
    reg [2:0] alert_mask;
    reg [7:0] crit_hyst;
    reg [3:0] queue_depth;
    reg [2:0] high_state;
    reg [7:0] next_rd_data;
    reg       next_mapped;

    wire [2:0] high_trip;
    wire [2:0] low_trip;
    wire [2:0] over_crit;
    wire [7:0] hyst_unused;

    wire standby = device_config[`TMR_CFG_STANDBY_BIT];
    // Strobes that clear the flag registers on their read
    wire rd_err  = rd_en && (addr == `TMR_A_ERR_FLAGS);
    wire rd_flt  = rd_en && (addr == `TMR_A_FAULT_FLAGS);

    assign config_out  = device_config;
    assign rate_out    = sample_rate;
    assign hyst_unused = crit_hyst;

    // ****************************************
    // Limit filters, a high and a low one per channel
    // ****************************************
    wire [23:0] temps  = {r2_temp, r1_temp, int_temp};
    wire [23:0] highs  = {r2_hi_int, r1_hi_int, int_hi};
    wire [23:0] lows   = {r2_lo_int, r1_lo_int, int_lo};
    wire [23:0] crits  = {r2_crit, r1_crit, int_crit};

    genvar c;
    generate
        for (c = 0; c < `TMR_CH_COUNT; c = c + 1) begin : g_q
            // Sample compared as it is captured, not after the register
            wire [7:0] sample_temp = meas_sel(c);
            wire       above_hi    = sample_temp >= highs[8*c+7:8*c];
            wire       below_lo    = sample_temp < lows[8*c+7:8*c];
            tmr_fault_queue u_hi (
                .clk          (clk),
                .rst_n        (rst_n),
                .sample       (meas_valid),
                .out_of_limit (above_hi),
                .depth        (queue_depth),
                .trip         (high_trip[c])
            );
            tmr_fault_queue u_lo (
                .clk          (clk),
                .rst_n        (rst_n),
                .sample       (meas_valid),
                .out_of_limit (below_lo),
                .depth        (queue_depth),
                .trip         (low_trip[c])
            );
        end
    endgenerate

    // Incoming sample for a channel, compared as it is captured
    function [7:0] meas_sel;
        input integer ch;
        begin
            case (ch)
                0:       meas_sel = meas_int_temp;
                1:       meas_sel = meas_r1_temp;
                default: meas_sel = meas_r2_temp;
            endcase
        end
    endfunction

    // ****************************************
    // Critical output
    // ****************************************
    // Every channel is linked to the critical output
    tmr_crit_ctl #(
        .CH (`TMR_CH_COUNT)
    ) u_crit (
        .clk    (clk),
        .rst_n  (rst_n),
        .temps  (temps),
        .limits (crits),
        .linked (3'b111),
        .hyst   (crit_hyst),
        .crit   (crit),
        .over   (over_crit)
    );

    // ****************************************
    // Host writes
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            device_config <= `TMR_RST_CONFIG;
            sample_rate   <= `TMR_RST_RATE;
            int_hi        <= `TMR_RST_HI_LIMIT;
            int_lo        <= `TMR_RST_ZERO;
            r1_hi_int     <= `TMR_RST_HI_LIMIT;
            r1_lo_int     <= `TMR_RST_ZERO;
            r1_hi_frac    <= `TMR_RST_ZERO;
            r1_lo_frac    <= `TMR_RST_ZERO;
            r2_hi_int     <= `TMR_RST_HI_LIMIT;
            r2_lo_int     <= `TMR_RST_ZERO;
            r2_hi_frac    <= `TMR_RST_ZERO;
            r2_lo_frac    <= `TMR_RST_ZERO;
            int_crit      <= `TMR_RST_CRIT;
            r1_crit       <= `TMR_RST_CRIT;
            r2_crit       <= `TMR_RST_CRIT;
            alert_mask    <= 3'h0;
            crit_hyst     <= `TMR_RST_HYST;
            queue_depth   <= RST_QUEUE_BYTE[7:4];
            one_shot      <= 1'b0;
        end else begin
            one_shot <= 1'b0;
            // Mirrors share one storage, read-only addresses fall through
            if (wr_en) begin
                case (addr)
                    `TMR_A_CONFIG, `TMR_A_CONFIG_M:       device_config <= wr_data;
                    `TMR_A_RATE, `TMR_A_RATE_M:           sample_rate   <= wr_data;
                    `TMR_A_INT_HI, `TMR_A_INT_HI_M:       int_hi        <= wr_data;
                    `TMR_A_INT_LO, `TMR_A_INT_LO_M:       int_lo        <= wr_data;
                    `TMR_A_R1_HI_INT, `TMR_A_R1_HI_INT_M: r1_hi_int     <= wr_data;
                    `TMR_A_R1_LO_INT, `TMR_A_R1_LO_INT_M: r1_lo_int     <= wr_data;
                    `TMR_A_ONE_SHOT:   one_shot    <= standby;
                    `TMR_A_R1_HI_FRAC: r1_hi_frac  <= wr_data;
                    `TMR_A_R1_LO_FRAC: r1_lo_frac  <= wr_data;
                    `TMR_A_R2_HI_INT:  r2_hi_int   <= wr_data;
                    `TMR_A_R2_LO_INT:  r2_lo_int   <= wr_data;
                    `TMR_A_R2_HI_FRAC: r2_hi_frac  <= wr_data;
                    `TMR_A_R2_LO_FRAC: r2_lo_frac  <= wr_data;
                    `TMR_A_R1_CRIT:    r1_crit     <= wr_data;
                    `TMR_A_R2_CRIT:    r2_crit     <= wr_data;
                    `TMR_A_INT_CRIT:   int_crit    <= wr_data;
                    `TMR_A_ALERT_MASK: alert_mask  <= wr_data[2:0];
                    `TMR_A_CRIT_HYST:  crit_hyst   <= wr_data;
                    `TMR_A_FAULT_QUEUE: queue_depth <= wr_data[7:4];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Measurement results
    // ****************************************
    // Fraction bytes are stored only, never compared
    always @(posedge clk) begin
        if (!rst_n) begin
            int_temp <= `TMR_RST_ZERO;
            r1_temp  <= `TMR_RST_ZERO;
            r1_frac  <= `TMR_RST_ZERO;
            r2_temp  <= `TMR_RST_ZERO;
            r2_frac  <= `TMR_RST_ZERO;
        end else if (meas_valid) begin
            int_temp <= meas_int_temp;
            r1_temp  <= meas_r1_temp;
            r1_frac  <= meas_r1_frac;
            r2_temp  <= meas_r2_temp;
            r2_frac  <= meas_r2_frac;
        end
    end

    // ****************************************
    // Status events
    // ****************************************
    wire ev_high  = |high_trip;
    wire ev_low   = |low_trip;
    wire ev_fault = meas_valid & |meas_fault;
    wire ev_crit  = |over_crit;

    // ****************************************
    // Clear-on-read flags, a set wins over the clear
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            err_flags   <= `TMR_RST_ZERO;
            fault_flags <= 2'h0;
            high_state  <= 3'h0;
        end else begin
            err_flags[`TMR_ERR_BUSY_BIT] <= meas_busy;
            err_flags[6:5]               <= 2'h0;
            err_flags[0]                 <= 1'b0;
            err_flags[`TMR_ERR_HIGH_BIT] <= ev_high
                | (err_flags[`TMR_ERR_HIGH_BIT] & !rd_err);
            err_flags[`TMR_ERR_LOW_BIT]  <= ev_low
                | (err_flags[`TMR_ERR_LOW_BIT] & !rd_err);
            err_flags[`TMR_ERR_FAULT_BIT] <= ev_fault
                | (err_flags[`TMR_ERR_FAULT_BIT] & !rd_err);
            err_flags[`TMR_ERR_CRIT_BIT] <= ev_crit
                | (err_flags[`TMR_ERR_CRIT_BIT] & !rd_err);
            // Fault bit 0 is remote one, bit 1 remote two
            fault_flags <= ({2{meas_valid}} & meas_fault)
                | (fault_flags & {2{!rd_flt}});
            high_state  <= high_trip | (high_state & {3{!rd_err}});
        end
    end

    // Alert follows unmasked high events until the status is read
    always @(posedge clk) begin
        if (!rst_n) begin
            alert <= 1'b0;
        end else begin
            alert <= |(high_state & ~alert_mask);
        end
    end

    // ****************************************
    // Host reads
    // ****************************************
    always @* begin
        next_mapped  = 1'b1;
        next_rd_data = 8'h00;
        case (addr)
            `TMR_A_INT_TEMP:                      next_rd_data = int_temp;
            `TMR_A_R1_TEMP:                       next_rd_data = r1_temp;
            `TMR_A_ERR_FLAGS:                     next_rd_data = err_flags;
            `TMR_A_CONFIG, `TMR_A_CONFIG_M:       next_rd_data = device_config;
            `TMR_A_RATE, `TMR_A_RATE_M:           next_rd_data = sample_rate;
            `TMR_A_INT_HI, `TMR_A_INT_HI_M:       next_rd_data = int_hi;
            `TMR_A_INT_LO, `TMR_A_INT_LO_M:       next_rd_data = int_lo;
            `TMR_A_R1_HI_INT, `TMR_A_R1_HI_INT_M: next_rd_data = r1_hi_int;
            `TMR_A_R1_LO_INT, `TMR_A_R1_LO_INT_M: next_rd_data = r1_lo_int;
            `TMR_A_R1_FRAC:                       next_rd_data = r1_frac;
            `TMR_A_R1_HI_FRAC:                    next_rd_data = r1_hi_frac;
            `TMR_A_R1_LO_FRAC:                    next_rd_data = r1_lo_frac;
            `TMR_A_R2_HI_INT:                     next_rd_data = r2_hi_int;
            `TMR_A_R2_LO_INT:                     next_rd_data = r2_lo_int;
            `TMR_A_R2_HI_FRAC:                    next_rd_data = r2_hi_frac;
            `TMR_A_R2_LO_FRAC:                    next_rd_data = r2_lo_frac;
            `TMR_A_R1_CRIT:                       next_rd_data = r1_crit;
            `TMR_A_R2_CRIT:                       next_rd_data = r2_crit;
            `TMR_A_FAULT_FLAGS:                   next_rd_data = {6'h00, fault_flags};
            `TMR_A_ALERT_MASK:                    next_rd_data = {5'h00, alert_mask};
            `TMR_A_INT_CRIT:                      next_rd_data = int_crit;
            `TMR_A_CRIT_HYST:                     next_rd_data = hyst_unused;
            `TMR_A_FAULT_QUEUE:                   next_rd_data = {queue_depth, 4'h0};
            `TMR_A_R2_TEMP:                       next_rd_data = r2_temp;
            `TMR_A_R2_FRAC:                       next_rd_data = r2_frac;
            default:                              next_mapped  = 1'b0;
        endcase
        if (!next_mapped) begin
            next_rd_data = 8'h00;
        end
    end

    // ****************************************
    // Read data register, holds until the next read
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end
    end

endmodule // tmr_regs
`default_nettype wire

// file: hw/tmr_defs.vh
// Register offsets, reset values and field positions of the thermal monitor register bank.
// Assumes inclusion by bare name from the design files.
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define TMR_A_INT_TEMP      8'h00
`define TMR_A_R1_TEMP       8'h01
`define TMR_A_ERR_FLAGS     8'h02
`define TMR_A_CONFIG        8'h03
`define TMR_A_RATE          8'h04
`define TMR_A_INT_HI        8'h05
`define TMR_A_INT_LO        8'h06
`define TMR_A_R1_HI_INT     8'h07
`define TMR_A_R1_LO_INT     8'h08
`define TMR_A_CONFIG_M      8'h09
`define TMR_A_RATE_M        8'h0A
`define TMR_A_INT_HI_M      8'h0B
`define TMR_A_INT_LO_M      8'h0C
`define TMR_A_R1_HI_INT_M   8'h0D
`define TMR_A_R1_LO_INT_M   8'h0E
`define TMR_A_ONE_SHOT      8'h0F
`define TMR_A_R1_FRAC       8'h10
`define TMR_A_R1_HI_FRAC    8'h13
`define TMR_A_R1_LO_FRAC    8'h14
`define TMR_A_R2_HI_INT     8'h15
`define TMR_A_R2_LO_INT     8'h16
`define TMR_A_R2_HI_FRAC    8'h17
`define TMR_A_R2_LO_FRAC    8'h18
`define TMR_A_R1_CRIT       8'h19
`define TMR_A_R2_CRIT       8'h1A
`define TMR_A_FAULT_FLAGS   8'h1B
`define TMR_A_ALERT_MASK    8'h1F
`define TMR_A_INT_CRIT      8'h20
`define TMR_A_CRIT_HYST     8'h21
`define TMR_A_FAULT_QUEUE   8'h22
`define TMR_A_R2_TEMP       8'h23
`define TMR_A_R2_FRAC       8'h24

// ****************************************
// Reset values
// ****************************************
`define TMR_RST_ZERO        8'h00
`define TMR_RST_CONFIG      8'h80
`define TMR_RST_RATE        8'h06
`define TMR_RST_HI_LIMIT    8'h55
`define TMR_RST_CRIT        8'h55
`define TMR_RST_HYST        8'h0A
`define TMR_RST_QUEUE       8'h70

// ****************************************
// Field positions
// ****************************************
`define TMR_CFG_STANDBY_BIT 6
`define TMR_ERR_BUSY_BIT    7
`define TMR_ERR_HIGH_BIT    4
`define TMR_ERR_LOW_BIT     3
`define TMR_ERR_FAULT_BIT   2
`define TMR_ERR_CRIT_BIT    1
`define TMR_MASK_INT_BIT    0
`define TMR_MASK_R1_BIT     1
`define TMR_MASK_R2_BIT     2
`define TMR_CH_COUNT        3

`endif

// file: hw/tmr_crit_ctl.v
// Critical output with shared hysteresis over all linked channels.
// Assumes temperatures and limits are unsigned integer bytes on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"

module tmr_crit_ctl #(
    parameter CH = 3
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // Temperatures and limits, channel i in byte i
    input  wire [8*CH-1:0]   temps,
    input  wire [8*CH-1:0]   limits,
    input  wire [CH-1:0]     linked,
    input  wire [7:0]        hyst,
    // Result
    output reg               crit,
    output wire [CH-1:0]     over
);

    wire [CH-1:0] below;

    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1) begin : g_ch
            wire [8:0] thr = {1'b0, limits[8*i+7:8*i]} - {1'b0, hyst};
            assign over[i]  = linked[i] && (temps[8*i+7:8*i] >= limits[8*i+7:8*i]);
            // Release threshold clamps at zero when the hysteresis exceeds the limit
            assign below[i] = !linked[i] || (!thr[8] && (temps[8*i+7:8*i] < thr[7:0]));
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_n) begin
            crit <= 1'b0;
        end else if (|over) begin
            crit <= 1'b1;
        end else if (&below) begin
            crit <= 1'b0;
        end
    end

endmodule // tmr_crit_ctl
`default_nettype wire

// file: hw/tmr_fault_queue.v
// Consecutive out-of-limit filter for one channel's limit event.
// Assumes one sample strobe per completed measurement.
`timescale 1ns/1ps
`default_nettype none

module tmr_fault_queue (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Sample and depth
    input  wire       sample,
    input  wire       out_of_limit,
    input  wire [3:0] depth,
    // Result, one-cycle pulse
    output reg        trip
);

    reg [3:0] count;

    always @(posedge clk) begin
        if (!rst_n) begin
            count <= 4'h0;
            trip  <= 1'b0;
        end else begin
            trip <= 1'b0;
            if (sample) begin
                if (!out_of_limit) begin
                    count <= 4'h0;
                end else if (count >= depth) begin
                    trip <= 1'b1;
                end else begin
                    count <= count + 4'h1;
                    trip  <= (count + 4'h1) >= depth;
                end
            end
        end
    end

endmodule // tmr_fault_queue
`default_nettype wire

// file: verification/tmr_regs_asserts.sv
// Port checker for the thermal monitor register bank.
// Assumes a bind onto tmr_regs, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tmr_regs_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Host port
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    // Engine side
    input wire logic       meas_valid,
    input wire logic [7:0] config_out,
    input wire logic [7:0] rate_out,
    input wire logic       one_shot,
    input wire logic       alert,
    input wire logic       crit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire cfg_wr  = wr_en && (addr == 8'h03 || addr == 8'h09);
    wire rate_wr = wr_en && (addr == 8'h04 || addr == 8'h0A);
    wire shot_wr = wr_en && addr == 8'h0F && config_out[6];
    wire dead_rd = rd_en && (addr == 8'h0F || addr == 8'h11 || addr == 8'h12 || addr > 8'h24
        || (addr >= 8'h1C && addr <= 8'h1E));
    // ****************************************
    // Assertions
    // ****************************************
    AST_CFG_MIRROR: assert property (cfg_wr |=> config_out == $past(wr_data))
        else $error("config write not stored");
    AST_CFG_HOLD: assert property (!cfg_wr |=> $stable(config_out))
        else $error("config changed without write");
    AST_RATE_MIRROR: assert property (rate_wr |=> rate_out == $past(wr_data))
        else $error("rate write not stored");
    AST_SHOT_PULSE: assert property (shot_wr |=> one_shot)
        else $error("no single conversion pulse");
    AST_SHOT_CAUSE: assert property (one_shot |-> $past(shot_wr))
        else $error("single conversion without standby write");
    AST_DEAD_READ: assert property (dead_rd |=> rd_data == 8'h00)
        else $error("empty address read not zero");
    AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved without read");
    AST_UNUSED_BITS: assert property (rd_en && addr == 8'h02 |=> rd_data[6:5] == 2'b00 && !rd_data[0])
        else $error("unused status bits set");
    AST_QUEUE_LOW: assert property (rd_en && addr == 8'h22 |=> rd_data[3:0] == 4'h0)
        else $error("unused queue bits set");
    AST_CRIT_CAUSE: assert property ($changed(crit) |-> $past(meas_valid, 2) || $past(wr_en, 2))
        else $error("critical output moved without cause");
    COV_SHOT: cover property (one_shot);
    COV_CRIT: cover property ($rose(crit));
    COV_ALERT: cover property ($rose(alert));
endmodule // tmr_regs_asserts
bind tmr_regs tmr_regs_asserts u_chk (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .meas_valid(meas_valid),
    .config_out(config_out), .rate_out(rate_out), .one_shot(one_shot), .alert(alert),
    .crit(crit));
`default_nettype wire

// file: verification/tmr_host_model.sv
// Host model driving the register port of the thermal monitor.
// Assumes one-cycle strobes and read data valid after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output var  logic       wr_en,
    output var  logic       rd_en,
    output var  logic [7:0] addr,
    output var  logic [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end
    // Data inverted after the strobe so nothing leans on stale data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule // tmr_host_model
`default_nettype wire

// file: verification/tmr_regs_test.sv
// Self-checking bench for the thermal monitor register bank.
// Assumes tmr_regs, the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tmr_regs_test;
    logic       clk;
    logic       rst_n;
    wire        wr_en;
    wire        rd_en;
    wire  [7:0] addr;
    wire  [7:0] wr_data;
    wire  [7:0] rd_data;
    logic       meas_valid;
    logic [7:0] r1_temp;
    logic [7:0] r2_temp;
    logic [1:0] fault;
    wire  [7:0] config_out;
    wire  [7:0] rate_out;
    wire        one_shot;
    wire        alert;
    wire        crit;
    logic [7:0] shadow [0:63];
    logic [7:0] v;
    logic [7:0] shots = 8'h00;
    int         mismatches = 0;
    int         compares = 0;
    int         cycles = 0;
    logic [7:0] t1 [0:5] = '{8'h54, 8'h55, 8'h4B, 8'h4A, 8'h55, 8'h54};
    logic       tc [0:5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    tmr_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data));
    tmr_regs dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .meas_valid(meas_valid),
        .meas_int_temp(8'h10), .meas_r1_temp(r1_temp), .meas_r1_frac(8'h80),
        .meas_r2_temp(r2_temp), .meas_r2_frac(8'h40), .meas_fault(fault),
        .meas_busy(1'b0), .config_out(config_out), .rate_out(rate_out),
        .one_shot(one_shot), .alert(alert), .crit(crit));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (one_shot === 1'b1) shots <= shots + 8'h01;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    function automatic logic [7:0] home(input logic [7:0] a);
        return (a >= 8'h09 && a <= 8'h0E) ? a - 8'h06 : a;
    endfunction
    function automatic logic is_rw(input logic [7:0] a);
        return (a >= 8'h03 && a <= 8'h08) || (a >= 8'h13 && a <= 8'h1A) || a == 8'h1F
            || (a >= 8'h20 && a <= 8'h22);
    endfunction
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            8'h03: return 8'h80;
            8'h04: return 8'h06;
            8'h05, 8'h07, 8'h15, 8'h19, 8'h1A, 8'h20: return 8'h55;
            8'h21: return 8'h0A;
            8'h22: return 8'h70;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp=%h got=%h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check($sformatf("reg_%h", a), exp, d);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic meas(input logic [7:0] r1, input logic [7:0] r2, input logic [1:0] f);
        @(posedge clk);
        #1;
        meas_valid = 1'b1;
        r1_temp = r1;
        r2_temp = r2;
        fault = f;
        settle(1);
        meas_valid = 1'b0;
        settle(3);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        settle(8);
        rst_n = 1'b1;
        foreach (shadow[i]) shadow[i] = rst_val(8'(i));
    endtask
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        meas_valid = 1'b0;
        r1_temp = 8'h00;
        r2_temp = 8'h00;
        fault = 2'b00;
        do_reset();
        for (int i = 0; i < 40; i++) rd_chk(8'(i), shadow[home(8'(i))]);
        $display("test reset_values done");
        for (int i = 0; i < 40; i++) begin
            host.wr(8'(i), 8'hC3 ^ 8'(i));
            if (is_rw(home(8'(i)))) shadow[home(8'(i))] = (8'hC3 ^ 8'(i))
                & (i == 34 ? 8'hF0 : i == 31 ? 8'h07 : 8'hFF);
        end
        for (int i = 0; i < 40; i++) rd_chk(8'(i), shadow[home(8'(i))]);
        check("config_out", shadow[3], config_out);
        check("rate_out", shadow[4], rate_out);
        $display("test write_readback done");
        do_reset();
        v = shots;
        host.wr(8'h0F, 8'h5A);
        settle(3);
        check("shot_idle", v, shots);
        host.wr(8'h03, 8'hC0);
        host.wr(8'h0F, 8'h00);
        settle(3);
        check("shot_standby", v + 8'h01, shots);
        $display("test single_conversion done");
        do_reset();
        for (int i = 0; i < 6; i++) begin
            if (i == 4) host.wr(8'h21, 8'h00);
            meas(t1[i], 8'h00, 2'b00);
            check("crit", {7'h00, tc[i]}, {7'h00, crit});
        end
        rd_chk(8'h00, 8'h10);
        rd_chk(8'h01, 8'h54);
        rd_chk(8'h10, 8'h80);
        rd_chk(8'h23, 8'h00);
        rd_chk(8'h24, 8'h40);
        $display("test critical_hysteresis done");
        do_reset();
        host.wr(8'h22, 8'h10);
        host.wr(8'h0E, 8'h20);
        meas(8'h00, 8'h60, 2'b01);
        check("alert_set", 8'h01, {7'h00, alert});
        host.rd(8'h02, v);
        check("status", 8'h1C, v & 8'h1C);
        rd_chk(8'h1B, 8'h01);
        rd_chk(8'h1B, 8'h00);
        host.rd(8'h02, v);
        check("status_clr", 8'h00, v & 8'h1C);
        check("alert_clr", 8'h00, {7'h00, alert});
        host.wr(8'h1F, 8'h04);
        meas(8'h00, 8'h60, 2'b00);
        check("alert_mask", 8'h00, {7'h00, alert});
        $display("test status_alert done");
        do_reset();
        for (int i = 0; i < 7; i++) begin
            meas(8'h00, 8'h60, 2'b00);
            host.rd(8'h02, v);
            check("queue", (i == 6) ? 8'h10 : 8'h00, v & 8'h10);
        end
        $display("test fault_queue done");
        final_report();
    end
endmodule // tmr_regs_test
`default_nettype wire
